// *** verilog/tc_burn_pkg.sv ***
/*
  Constants, field layouts and carrier types for the time code window overlay.
  Assumes one 40 MHz system clock and a luma-only pixel stream on that clock.
*/
`default_nettype none
package tc_burn_pkg;
  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_SYNC = 4'h4;
  localparam logic [3:0] A_STAT = 4'h8;
  localparam logic [3:0] A_TC   = 4'hc;

  // Control register layout, bit 0 upward: on, size, vpos, hpos, colour, reference.
  typedef struct packed {
    logic [1:0] pos_ref;
    logic [1:0] color;
    logic [2:0] hpos;
    logic [2:0] vpos;
    logic       size;
    logic       on;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = 12'h000;

  // Positional reference codes.
  localparam logic [1:0] PR_LTC  = 2'h0;
  localparam logic [1:0] PR_VITC = 2'h1;
  localparam logic [1:0] PR_AUTO = 2'h2;
  localparam logic [1:0] PR_GEN  = 2'h3;

  // Menu items: 0 clock source, 1 sample rate, 2 small pull, 3 large pull,
  // 4 word clock multiple, 5 insert on, 6 read lines, 7 write lines, 8 overlay.
  localparam logic [3:0]        P_LAST    = 4'h8;
  localparam logic [3:0]        P_WLINE   = 4'h7;
  localparam logic [31:0]       CFG_RST   = 32'h4000_0000;
  localparam logic [8:0][3:0]   PARAM_CNT = 36'h2_8_9_2_2_3_3_6_2;
  localparam logic [8:0][63:0]  NAME_SEG  = {
    64'h7c1c5054_79547700, 64'h7d795400_38065479, 64'h505e5000_38065479,
    64'h3e060739_0006546d, 64'h7c776d79_39383f39, 64'h731c3838_50077966,
    64'h731c3838_50077906, 64'h6d733800_71507939, 64'h5e067d00_50797100};

  // ----------------------------------------------------------------------
  // Picture geometry and character cell
  // ----------------------------------------------------------------------
  localparam logic [9:0] PIC_W   = 10'd720;
  localparam logic [8:0] PIC_H   = 9'd480;
  localparam logic [8:0] V_STEP  = 9'd48;
  localparam logic [9:0] WIN_W   = 10'd64;
  localparam logic [8:0] WIN_H   = 9'd12;
  localparam logic [4:0][9:0] H_CENTER = {10'd648, 10'd504, 10'd360, 10'd216, 10'd72};
  localparam logic [7:0] LUMA_WHITE = 8'heb;
  localparam logic [7:0] LUMA_BLACK = 8'h10;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 40_000_000;
  localparam int unsigned LOSS_MS  = 100;
  localparam int unsigned LOSS_CYC = LOSS_MS * (CLK_HZ / 1000);

  // Key bit positions.
  localparam int K_SEL = 0;
  localparam int K_UP  = 1;
  localparam int K_DN  = 2;

  typedef enum logic [2:0] {
    M_IDLE   = 3'b001,
    M_BROWSE = 3'b010,
    M_EDIT   = 3'b100
  } menu_t;

  typedef struct packed {
    logic       sof;
    logic       sol;
    logic       valid;
    logic [7:0] luma;
  } vid_t;
endpackage
`default_nettype wire

// *** verilog/timecode_window_burn_overlay.sv ***
/*
  Time code window overlay with front panel menu and synchroniser settings.
  Assumes the pixel stream and time code inputs come from logic on clk_sys;
  keys, reader activity and stored line setting are asynchronous pins.
*/
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
// Functional notes
// - Overlay shows hh:mm:ss:ff window when enabled.
// - Displayed code follows selected positional reference.
// - Overlay only appears on present incoming video.
// - Size selects small or large window.
// - Vertical position 10% to 50% from bottom.
// - Five horizontal positions, far left to far right.
// - Four colour modes, boxed or transparent.
// - Colour defaults to white on black.
// - Keys edit every menu item, overlay included; all also via bus.
// - Select enters browsing; up/down step parameters.
// - Select shows value, up/down cycle, select commits.
// - Display shows fixed abbreviated parameter names.
// - Every passing frame gets the window burned in.
// - Two pull settings, small and large.
// - Word clock output base or 256x.
// - Base rate 44.1 or 48 kHz family.
// - Insert only with video and permitting mode.
// - Read lines fixed pair or automatic scan.
// - Write line pair selectable, default 14/16.
// - Write line pair kept in non-volatile storage.
// - Digital clock from AES/EBU or word clock.
// - Never insert while reading or VITC reference.
`timescale 1ns/1ps
`default_nettype none
module timecode_window_burn_overlay #(
  parameter int unsigned LOSS_CYC = tc_burn_pkg::LOSS_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire tc_burn_pkg::vid_t vid_in,
  output tc_burn_pkg::vid_t      vid_out,
  input  wire logic [31:0]       tc_ltc,
  input  wire logic [31:0]       tc_vitc,
  input  wire logic [31:0]       tc_gen,
  input  wire logic [2:0]        keys,
  input  wire logic              vitc_reading,
  input  wire logic              nv_valid,
  input  wire logic [3:0]        nv_line,
  output logic                   nv_write,
  output logic      [3:0]        nv_data,
  output logic      [63:0]       disp_seg,
  output logic                   vertical_code_insert_on,
  output logic      [3:0]        vertical_code_write_lines,
  output logic      [3:0]        read_line_sel,
  output logic      [1:0]        small_pull_select,
  output logic      [1:0]        large_pull_select,
  output logic                   word_clock_out_multiple,
  output logic                   base_rate_48k,
  output logic                   digital_clock_source
);
  // ----------------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
    tc_burn_pkg::ctrl_t ctrl;
    logic [7:0][3:0]    cfg;
    tc_burn_pkg::menu_t ms;
    logic [3:0]         midx;
    logic [3:0]         mval;
    logic [2:0]         k1;
    logic [2:0]         k2;
    logic [2:0]         k3;
    logic               vr1;
    logic               vr2;
    logic [4:0]         nv1;
    logic [4:0]         nv2;
    logic [1:0]         ld;
    logic [9:0]         h;
    logic [8:0]         v;
    logic               seen;
    logic [21:0]        lcnt;
    tc_burn_pkg::vid_t  vout;
    logic [63:0]        disp;
    logic               nvw;
    logic [3:0]         nvd;
  } state_t;
  localparam state_t ST_RST = '{ms: tc_burn_pkg::M_IDLE, cfg: tc_burn_pkg::CFG_RST,
                                ctrl: tc_burn_pkg::CTRL_RST, default: '0};

  state_t st_reg;
  state_t st_next;

  // Segment pattern, gfedcba, for a decimal digit; other codes blank.
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      default: seg7 = 7'h00;
    endcase
  endfunction

  // Whether a cell pixel lies on a lit stroke of a seven-segment glyph.
  function automatic logic glyph(input logic [6:0] s, input logic [2:0] x,
                                 input logic [3:0] y);
    logic top;
    logic bot;
    logic mid;
    top = (y >= 4'd1) && (y <= 4'd6);
    bot = (y >= 4'd6) && (y <= 4'd10);
    mid = (x >= 3'd1) && (x <= 3'd6);
    glyph = (s[0] && y == 4'd1 && mid) || (s[1] && x == 3'd6 && top) ||
            (s[2] && x == 3'd6 && bot) || (s[3] && y == 4'd10 && mid) ||
            (s[4] && x == 3'd1 && bot) || (s[5] && x == 3'd1 && top) ||
            (s[6] && y == 4'd6 && mid);
  endfunction

  // Byte-lane merge of a bus write into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      o[8*b +: 8] = be[b] ? w[8*b +: 8] : o[8*b +: 8];
    end
    merge = o;
  endfunction

  // ----------------------------------------------------------------------
  // Source selection, video presence and window geometry
  // ----------------------------------------------------------------------
  logic [31:0] tc_sel;
  logic        present;
  logic [9:0]  nh;
  logic [8:0]  nv;
  logic [9:0]  ww;
  logic [8:0]  wh;
  logic [9:0]  xl;
  logic [8:0]  yt;
  logic [9:0]  dx;
  logic [8:0]  dy;
  logic        inwin;
  logic [8:0]  px;
  logic [3:0]  cy;
  logic [3:0]  digit;
  logic        hit;
  logic        ins_ok;
  logic [2:0]  kedge;
  logic        wr_go;
  logic [63:0] disp_tc;
  logic [3:0]  cur;
  logic [2:0]  vsel;
  logic [2:0]  hsel;

  // Time code from whichever positional reference is selected.
  always_comb begin
    unique case (st_reg.ctrl.pos_ref)
      tc_burn_pkg::PR_LTC:  tc_sel = tc_ltc;
      tc_burn_pkg::PR_VITC: tc_sel = tc_vitc;
      tc_burn_pkg::PR_AUTO: tc_sel = st_reg.vr2 ? tc_vitc : tc_ltc;
      tc_burn_pkg::PR_GEN:  tc_sel = tc_gen;
    endcase
  end

  // Coordinates of the pixel now arriving and the window it is tested against.
  assign present = st_reg.seen && (st_reg.lcnt < 22'(LOSS_CYC));
  assign nh      = (vid_in.sof || vid_in.sol) ? 10'd0 : st_reg.h + 10'd1;
  assign nv      = vid_in.sof ? 9'd0 : (vid_in.sol ? st_reg.v + 9'd1 : st_reg.v);
  assign ww      = st_reg.ctrl.size ? {tc_burn_pkg::WIN_W[8:0], 1'b0}
                                    : tc_burn_pkg::WIN_W;
  assign wh      = st_reg.ctrl.size ? {tc_burn_pkg::WIN_H[7:0], 1'b0}
                                    : tc_burn_pkg::WIN_H;
  assign vsel    = (st_reg.ctrl.vpos > 3'd4) ? 3'd4 : st_reg.ctrl.vpos;
  assign hsel    = (st_reg.ctrl.hpos > 3'd4) ? 3'd4 : st_reg.ctrl.hpos;
  assign xl      = tc_burn_pkg::H_CENTER[hsel] - {1'b0, ww[9:1]};
  assign yt      = 9'(tc_burn_pkg::PIC_H - 9'(tc_burn_pkg::V_STEP * 9'(vsel + 3'd1)) - wh);
  assign dx      = nh - xl;
  assign dy      = nv - yt;
  assign inwin   = (nh >= xl) && (dx < ww) && (nv >= yt) && (dy < wh);
  assign px      = st_reg.ctrl.size ? dx[9:1] : dx[8:0];
  assign cy      = st_reg.ctrl.size ? dy[4:1] : dy[3:0];
  assign digit   = 4'(tc_sel >> {~px[5:3], 2'b00});
  assign hit     = glyph(seg7(digit), px[2:0], cy);

  // Insertion is allowed only with video and a mode that is not reading it.
  assign ins_ok  = present && !st_reg.vr2 && (st_reg.ctrl.pos_ref != tc_burn_pkg::PR_VITC)
                   && (st_reg.ctrl.pos_ref != tc_burn_pkg::PR_AUTO);

  assign kedge   = st_reg.k2 & ~st_reg.k3;
  assign wr_go   = st_reg.ack && avs_write;
  assign cur     = (st_reg.midx == tc_burn_pkg::P_LAST) ? {3'b000, st_reg.ctrl.on}
                                                        : st_reg.cfg[st_reg.midx[2:0]];

  // Time code digits for the idle display, most significant on the left.
  for (genvar i = 0; i < 8; i++) begin : g_disp
    assign disp_tc[8*i +: 8] = {1'b0, seg7(tc_sel[4*i +: 4])};
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Bus slave, menu, synchronisers, stored line load and pixel path.
  always_comb begin
    logic [31:0] m;
    m       = '0;
    st_next = st_reg;
    st_next.k1  = keys;
    st_next.k2  = st_reg.k1;
    st_next.k3  = st_reg.k2;
    st_next.vr1 = vitc_reading;
    st_next.vr2 = st_reg.vr1;
    st_next.nv1 = {nv_valid, nv_line};
    st_next.nv2 = st_reg.nv1;
    // Stored write line pair is restored once its synchroniser has settled.
    if (st_reg.ld != 2'd3) begin
      st_next.ld = st_reg.ld + 2'd1;
    end
    if (st_reg.ld == 2'd2 && st_reg.nv2[4] && st_reg.nv2[3:0] < 4'd8) begin
      st_next.cfg[7] = st_reg.nv2[3:0];
    end
    // Menu walk: browse names, edit a value, commit on select.
    unique case (st_reg.ms)
      tc_burn_pkg::M_IDLE: begin
        if (kedge[tc_burn_pkg::K_SEL]) begin
          st_next.ms   = tc_burn_pkg::M_BROWSE;
          st_next.midx = 4'h0;
        end
      end
      tc_burn_pkg::M_BROWSE: begin
        if (kedge[tc_burn_pkg::K_SEL]) begin
          st_next.ms   = tc_burn_pkg::M_EDIT;
          st_next.mval = cur;
        end else if (kedge[tc_burn_pkg::K_UP]) begin
          st_next.midx = (st_reg.midx == tc_burn_pkg::P_LAST) ? 4'h0 : st_reg.midx + 4'h1;
        end else if (kedge[tc_burn_pkg::K_DN]) begin
          st_next.midx = (st_reg.midx == 4'h0) ? tc_burn_pkg::P_LAST : st_reg.midx - 4'h1;
        end
      end
      tc_burn_pkg::M_EDIT: begin
        if (kedge[tc_burn_pkg::K_SEL]) begin
          st_next.ms = tc_burn_pkg::M_IDLE;
          if (st_reg.midx == tc_burn_pkg::P_LAST) begin
            st_next.ctrl.on = st_reg.mval[0];
          end else begin
            st_next.cfg[st_reg.midx[2:0]] = st_reg.mval;
          end
        end else if (kedge[tc_burn_pkg::K_UP]) begin
          st_next.mval = (st_reg.mval == tc_burn_pkg::PARAM_CNT[st_reg.midx] - 4'h1)
                         ? 4'h0 : st_reg.mval + 4'h1;
        end else if (kedge[tc_burn_pkg::K_DN]) begin
          st_next.mval = (st_reg.mval == 4'h0)
                         ? tc_burn_pkg::PARAM_CNT[st_reg.midx] - 4'h1 : st_reg.mval - 4'h1;
        end
      end
    endcase
    // Bus: answer one cycle after the request, write lands at the answer edge.
    st_next.ack = (avs_read || avs_write) && !st_reg.ack;
    if (st_next.ack) begin
      unique case (avs_address)
        tc_burn_pkg::A_CTRL: st_next.rdata = {20'h0, st_reg.ctrl};
        tc_burn_pkg::A_SYNC: st_next.rdata = st_reg.cfg;
        tc_burn_pkg::A_STAT: st_next.rdata = {22'h0, st_reg.vr2, st_reg.midx, st_reg.ms,
                                              vertical_code_insert_on, present};
        tc_burn_pkg::A_TC:   st_next.rdata = tc_sel;
        default:             st_next.rdata = 32'h0;
      endcase
    end
    if (wr_go && avs_address == tc_burn_pkg::A_CTRL) begin
      m = merge({20'h0, st_reg.ctrl}, avs_writedata, avs_byteenable);
      st_next.ctrl = tc_burn_pkg::ctrl_t'(m[11:0]);
      if (m[4:2] > 3'd4) st_next.ctrl.vpos = st_reg.ctrl.vpos;
      if (m[7:5] > 3'd4) st_next.ctrl.hpos = st_reg.ctrl.hpos;
    end
    if (wr_go && avs_address == tc_burn_pkg::A_SYNC) begin
      m = merge(st_reg.cfg, avs_writedata, avs_byteenable);
      for (int j = 0; j < 8; j++) begin
        if (m[4*j +: 4] < tc_burn_pkg::PARAM_CNT[j]) st_next.cfg[j] = m[4*j +: 4];
      end
    end
    // Write line changes are handed to non-volatile storage.
    st_next.nvw = (st_reg.ld == 2'd3) && (st_next.cfg[7] != st_reg.cfg[7]);
    st_next.nvd = st_next.cfg[7];
    // Display: time code, parameter name or edited value.
    unique case (st_next.ms)
      tc_burn_pkg::M_IDLE:   st_next.disp = disp_tc;
      tc_burn_pkg::M_BROWSE: st_next.disp = tc_burn_pkg::NAME_SEG[st_next.midx];
      tc_burn_pkg::M_EDIT:   st_next.disp = {56'h0, 1'b0, seg7(st_next.mval)};
    endcase
    // Raster counters and video presence.
    if (st_reg.lcnt != 22'h3fffff) st_next.lcnt = st_reg.lcnt + 22'h1;
    if (vid_in.valid) begin
      st_next.h = nh;
      st_next.v = nv;
      if (vid_in.sof) begin
        st_next.seen = 1'b1;
        st_next.lcnt = 22'h0;
      end
    end
    // Pixel path: burn every frame while enabled and video is present.
    st_next.vout = vid_in;
    if (vid_in.valid && st_reg.ctrl.on && present && inwin) begin
      if (hit) begin
        st_next.vout.luma = st_reg.ctrl.color[0] ? tc_burn_pkg::LUMA_BLACK
                                                 : tc_burn_pkg::LUMA_WHITE;
      end else if (!st_reg.ctrl.color[1]) begin
        st_next.vout.luma = st_reg.ctrl.color[0] ? tc_burn_pkg::LUMA_WHITE
                                                 : tc_burn_pkg::LUMA_BLACK;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Bus handshake from the request and st_reg.ack; settings straight from the state register, except insert on, which is gated by ins_ok.
  assign avs_waitrequest           = (avs_read || avs_write) && !st_reg.ack;
  assign avs_readdata              = st_reg.rdata;
  assign vid_out                   = st_reg.vout;
  assign disp_seg                  = st_reg.disp;
  assign nv_write                  = st_reg.nvw;
  assign nv_data                   = st_reg.nvd;
  assign vertical_code_insert_on   = st_reg.cfg[5][0] && ins_ok;
  assign vertical_code_write_lines = st_reg.cfg[7];
  assign read_line_sel             = st_reg.cfg[6];
  assign small_pull_select         = st_reg.cfg[2][1:0];
  assign large_pull_select         = st_reg.cfg[3][1:0];
  assign word_clock_out_multiple   = st_reg.cfg[4][0];
  assign base_rate_48k             = st_reg.cfg[1][0];
  assign digital_clock_source      = st_reg.cfg[0][0];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_reset_colour: assert property ((st_reg.ld == 2'd0) |-> (st_reg.ctrl.color == 2'd0
    && st_reg.cfg[7] == 4'h4)) else $error("reset colour or line pair wrong");
  chk_no_video_pass: assert property ((!present && vid_in.valid && st_reg.ld != 2'd0) |=>
    (vid_out == $past(vid_in))) else $error("video altered without presence");
  chk_insert_block: assert property ((st_reg.vr2 || st_reg.ctrl.pos_ref ==
    tc_burn_pkg::PR_VITC || st_reg.ctrl.pos_ref == tc_burn_pkg::PR_AUTO)
    |-> !vertical_code_insert_on) else $error("insert while reading");
  chk_insert_video: assert property (vertical_code_insert_on |-> present)
    else $error("insert without video");
  chk_browse_enter: assert property ((st_reg.ms == tc_burn_pkg::M_IDLE &&
    kedge[tc_burn_pkg::K_SEL]) |=> (st_reg.ms == tc_burn_pkg::M_BROWSE && st_reg.midx == 4'h0))
    else $error("select did not enter browsing");
  chk_edit_commit: assert property ((st_reg.ms == tc_burn_pkg::M_EDIT &&
    kedge[tc_burn_pkg::K_SEL] && st_reg.midx < 4'h8 && !wr_go) |=>
    (st_reg.cfg[$past(st_reg.midx[2:0])] == $past(st_reg.mval)))
    else $error("commit lost");
  chk_bus_answer: assert property (((avs_read || avs_write) && avs_waitrequest) |=>
    !avs_waitrequest) else $error("answer late");
  chk_nv_write: assert property (($past(st_reg.ld) == 2'd3 && $changed(st_reg.cfg[7]))
    |-> (nv_write && nv_data == st_reg.cfg[7])) else $error("line pair not stored");
  chk_transparent: assert property ((vid_in.valid && st_reg.ctrl.on && present && inwin
    && !hit && st_reg.ctrl.color[1]) |=> (vid_out.luma == $past(vid_in.luma)))
    else $error("transparent pixel changed");

  cov_commit: cover property (st_reg.ms == tc_burn_pkg::M_EDIT ##1
    st_reg.ms == tc_burn_pkg::M_IDLE);
  cov_insert: cover property (vertical_code_insert_on);
  cov_burn:   cover property (vid_in.valid && st_reg.ctrl.on && present && inwin && hit);
endmodule
`default_nettype wire

// *** tb/vid_partner.sv ***
/*
  Video source and recorder model for the overlay bench.
  Assumes the design hands the stream back one clk_sys cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module vid_partner (
  input  wire logic              clk_sys,
  input  wire logic              run,
  input  wire tc_burn_pkg::vid_t vid_out,
  output tc_burn_pkg::vid_t      vid_in,
  output int                     frames,
  output int                     st [8]
);
  int acc [8];
  int h;
  int v;

  // Source: grey frames, one-pixel lines except the rows around the window.
  always begin
    vid_in <= '0;
    @(posedge clk_sys);
    if (run) begin
      for (int r = 0; r < 245; r++) begin
        for (int c = 0; c < ((r > 210) ? 140 : 1); c++) begin
          vid_in <= '{(r == 0 && c == 0), (c == 0 && r != 0), 1'b1, 8'h80};
          @(posedge clk_sys);
        end
      end
    end
  end

  // Recorder: tallies altered pixels and their extent, published at frame start.
  always @(posedge clk_sys) begin
    if (vid_out.valid === 1'b1) begin
      h = (vid_out.sof || vid_out.sol) ? 0 : h + 1;
      v = vid_out.sof ? 0 : v + int'(vid_out.sol);
      if (vid_out.sof) begin
        st = acc;
        frames++;
        acc = '{0, 0, 0, 0, 999, 0, 999, 0};
      end
      if (vid_out.luma !== 8'h80) begin
        if (vid_out.luma === tc_burn_pkg::LUMA_WHITE) acc[1]++;
        else if (vid_out.luma === tc_burn_pkg::LUMA_BLACK) acc[2]++;
        else acc[3]++;
        acc[4] = (h < acc[4]) ? h : acc[4];
        acc[5] = (h > acc[5]) ? h : acc[5];
        acc[6] = (v < acc[6]) ? v : acc[6];
        acc[7] = (v > acc[7]) ? v : acc[7];
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/timecode_window_burn_overlay_tb_top.sv ***
/*
  Self-checking bench for the time code window overlay.
  Assumes the design package and vid_partner are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module timecode_window_burn_overlay_tb_top;
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic [3:0]        avs_address = 4'h0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  tc_burn_pkg::vid_t vid_in;
  tc_burn_pkg::vid_t vid_out;
  logic [31:0]       tc [3] = '{32'h01020304, 32'h05060708, 32'h09101112};
  logic [2:0]        keys = 3'h0;
  logic              vitc_reading = 1'b0;
  logic              nv_valid = 1'b0;
  logic [3:0]        nv_line = 4'h6;
  logic              nv_write, vertical_code_insert_on, word_clock_out_multiple;
  logic              base_rate_48k, digital_clock_source;
  logic [3:0]        nv_data, vertical_code_write_lines, read_line_sel;
  logic [1:0]        small_pull_select, large_pull_select;
  logic [63:0]       disp_seg;
  logic              run = 1'b0;
  logic [31:0]       q;
  logic [51:0]       win_exp [2] = '{{12'd768, 10'd40, 10'd103, 10'd228, 10'd239},
                                     {12'd3072, 10'd8, 10'd135, 10'd216, 10'd239}};
  int                frames, st [8], n_mismatch = 0, samples_checked = 0, nv_cnt = 0;
  wire [14:0]        sync_o = {digital_clock_source, base_rate_48k, small_pull_select,
                               large_pull_select, word_clock_out_multiple, read_line_sel,
                               vertical_code_write_lines};

  timecode_window_burn_overlay #(.LOSS_CYC(6000)) timecode_window_burn_overlay_i (
    .clk_sys, .arst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable(4'hf),
    .avs_writedata, .avs_readdata, .avs_waitrequest, .vid_in, .vid_out, .tc_ltc(tc[0]),
    .tc_vitc(tc[1]), .tc_gen(tc[2]), .keys, .vitc_reading, .nv_valid, .nv_line, .nv_write,
    .nv_data, .disp_seg, .vertical_code_insert_on, .vertical_code_write_lines,
    .read_line_sel, .small_pull_select, .large_pull_select, .word_clock_out_multiple,
    .base_rate_48k, .digital_clock_source);

  vid_partner vid_partner_i (.clk_sys, .run, .vid_out, .vid_in, .frames, .st);

  // Clock at 40 MHz, and a tally of store pulses.
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (nv_write === 1'b1) nv_cnt++;

  // Compares one value and reports a mismatch.
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One bus transfer; read data lands in q, held until waitrequest drops.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int t = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 40);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) n_mismatch++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // Reads a register and compares it.
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), q, e);
  endtask

  // Waits until one whole frame has been seen since the call.
  task automatic two_frames();
    int n = frames;
    while (frames < n + 2) @(posedge clk_sys);
  endtask

  // Presses one key long enough to clear the synchroniser.
  task automatic key(input int k);
    keys[k] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    keys[k] <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog sized well above the roughly 72k cycles the tests take.
  initial begin
    repeat (98000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end

  // Main sequence: settings, reference, insertion, window, keys, stored line.
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rc(tc_burn_pkg::A_CTRL, 32'h0);
    rc(tc_burn_pkg::A_SYNC, tc_burn_pkg::CFG_RST);
    bus(1'b1, tc_burn_pkg::A_SYNC, 32'h5301_2131);
    chk("sync", sync_o, 15'h6d35);
    chk("nv", {nv_cnt[3:0], nv_data}, 8'h15);
    bus(1'b1, tc_burn_pkg::A_SYNC, 32'h5301_2331);
    rc(tc_burn_pkg::A_SYNC, 32'h5301_2131);
    for (int r = 0; r < 6; r++) begin
      bus(1'b1, tc_burn_pkg::A_SYNC, {24'h530121, r[3:0], 4'h1});
      chk("rate", base_rate_48k, r[0]);
    end
    run <= 1'b1;
    two_frames();
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, tc_burn_pkg::A_CTRL, 32'(p << 10));
      bus(1'b1, tc_burn_pkg::A_SYNC, 32'h5311_2131);
      rc(tc_burn_pkg::A_TC, tc[(p == 3) ? 2 : p % 2]);
      chk("ins", vertical_code_insert_on, (p == 0 || p == 3));
    end
    vitc_reading <= 1'b1;
    bus(1'b1, tc_burn_pkg::A_CTRL, 32'h800);
    rc(tc_burn_pkg::A_TC, tc[1]);
    bus(1'b1, tc_burn_pkg::A_CTRL, 32'h0);
    chk("ins", vertical_code_insert_on, 1'b0);
    vitc_reading <= 1'b0;
    rc(tc_burn_pkg::A_TC, tc[0]);
    bus(1'b0, tc_burn_pkg::A_STAT, 32'h0);
    chk("live", q[1:0], 2'h3);
    run <= 1'b0;
    repeat (7000) @(posedge clk_sys);
    bus(1'b0, tc_burn_pkg::A_STAT, 32'h0);
    chk("lost", {q[1:0], vertical_code_insert_on}, 3'h0);
    run <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      logic [51:0] w;
      bus(1'b1, tc_burn_pkg::A_CTRL, (c == 5) ? 32'h10 : (c == 4) ? 32'h13 : 32'(17 | c << 8));
      two_frames();
      w = {12'(st[1] + st[2]), st[4][9:0], st[5][9:0], st[6][9:0], st[7][9:0]};
      chk("other", st[3], 0);
      if (c == 5) chk("off", st[1] + st[2], 0);
      else if (c == 2 || c == 3)
        chk("see", {st[4 - c] == 0, st[c - 1] > 0, st[c - 1] < 768}, 7);
      else chk("win", w, win_exp[c == 4]);
    end
    bus(1'b1, tc_burn_pkg::A_CTRL, 32'hb5);
    rc(tc_burn_pkg::A_CTRL, 32'h11);
    key(tc_burn_pkg::K_SEL);
    repeat (8) key(tc_burn_pkg::K_UP);
    chk("name", disp_seg, tc_burn_pkg::NAME_SEG[8]);
    bus(1'b0, tc_burn_pkg::A_STAT, 32'h0);
    chk("menu", q[8:2], {4'h8, tc_burn_pkg::M_BROWSE});
    key(tc_burn_pkg::K_SEL);
    key(tc_burn_pkg::K_UP);
    key(tc_burn_pkg::K_SEL);
    rc(tc_burn_pkg::A_CTRL, 32'h10);
    key(tc_burn_pkg::K_SEL);
    key(tc_burn_pkg::K_SEL);
    key(tc_burn_pkg::K_DN);
    key(tc_burn_pkg::K_SEL);
    chk("edit", digital_clock_source, 1'b0);
    nv_valid <= 1'b1;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("nvload", {nv_cnt[3:0], vertical_code_write_lines}, 8'h16);
    finish_test();
  end
endmodule
`default_nettype wire
